// ==== dv/mvl_lookup_monitor.sv ====
// assertion checker for the mac and vlan lookup block
`timescale 1ns/10ps
module mvl_lookup_monitor
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// host side
	input wire logic ctrl_wr,
	input wire logic [15:0] indirect_access_control_word,
	input wire logic [7:0] indirect_data_word_one_q,
	// configuration
	input wire logic vlan_mode_en,
	input wire logic [11:0] default_vid_p1,
	input wire logic [11:0] default_vid_p2,
	input wire logic [11:0] default_vid_p3,
	// packet side
	input wire logic pkt_valid,
	input wire logic [1:0] pkt_ingress,
	input wire logic pkt_tagged,
	input wire logic [11:0] pkt_tag_vid,
	input wire logic static_hit,
	input wire logic [2:0] static_ports,
	input wire logic pkt_ready_q,
	input wire logic fwd_valid_q,
	input wire logic fwd_drop_q,
	input wire logic [2:0] fwd_ports_q,
	input wire logic [11:0] fwd_vid_q
);
	logic take;
	logic [2:0] ing_mask;
	logic [11:0] vid_exp;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	// packet acceptance, ingress mask and the vid it should get
	always_comb
	begin
		take = pkt_valid && pkt_ready_q;
		ing_mask = 3'h1 << pkt_ingress;
		vid_exp = pkt_tag_vid;
		if (!pkt_tagged || pkt_tag_vid == 12'h000)
			vid_exp = (pkt_ingress == 2'h0) ? default_vid_p1 :
				(pkt_ingress == 2'h1) ? default_vid_p2 : default_vid_p3;
	end
	// result shapes and the learned read handshake
	sequence s_drop;
		##2 fwd_valid_q && fwd_drop_q;
	endsequence
	sequence s_fwd;
		##4 fwd_valid_q && !fwd_drop_q;
	endsequence
	sequence s_lrn_rd;
		ctrl_wr && indirect_access_control_word[12] &&
			indirect_access_control_word[11:10] == 2'h2;
	endsequence
	sequence s_rd_done;
		indirect_data_word_one_q[7] ##[1:5] !indirect_data_word_one_q[7];
	endsequence
	result_latency_a: assert property (take |-> s_drop or s_fwd)
		else $error("result not at fixed latency");
	drop_pulse_a: assert property (fwd_drop_q |-> fwd_valid_q ##1 !fwd_valid_q)
		else $error("drop flag without single result pulse");
	plain_mode_a: assert property (take && !vlan_mode_en |-> s_fwd)
		else $error("packet dropped with vlan mode off");
	egress_mask_a: assert property (take ##4 fwd_valid_q |->
		(fwd_ports_q & $past(ing_mask, 4)) == 3'h0)
		else $error("ingress port in egress mask");
	static_wins_a: assert property (take && static_hit ##4
		fwd_valid_q && !fwd_drop_q |->
		fwd_ports_q == ($past(static_ports, 4) & ~$past(ing_mask, 4)))
		else $error("static result not used");
	vid_assign_a: assert property (take && vlan_mode_en |->
		(##2 fwd_valid_q && fwd_drop_q && fwd_vid_q == $past(vid_exp, 2)) or
		(##4 fwd_valid_q && !fwd_drop_q && fwd_vid_q == $past(vid_exp, 4)))
		else $error("wrong vid assigned");
	host_read_a: assert property (s_lrn_rd |=> s_rd_done)
		else $error("learned read not ready in time");
	empty_reset_a: assert property ($rose(rst_b) |->
		indirect_data_word_one_q == 8'h04)
		else $error("empty flag not set after reset");
endmodule
bind mvl_lookup_top mvl_lookup_monitor i_mvl_lookup_monitor (.clock, .rst_b,
	.ctrl_wr, .indirect_access_control_word, .indirect_data_word_one_q,
	.vlan_mode_en, .default_vid_p1, .default_vid_p2, .default_vid_p3,
	.pkt_valid, .pkt_ingress, .pkt_tagged, .pkt_tag_vid, .static_hit,
	.static_ports, .pkt_ready_q, .fwd_valid_q, .fwd_drop_q, .fwd_ports_q,
	.fwd_vid_q);

// ==== dv/tb_mvl_lookup_top.sv ====
// self-checking testbench for the mac and vlan lookup block
`timescale 1ns/10ps
module tb_mvl_lookup_top;
	typedef struct packed {
		logic [1:0] ing;
		logic tg;
		logic [11:0] tv;
		logic [47:0] da;
		logic [47:0] sa;
		logic sh;
		logic [2:0] sp;
		logic drop;
		logic [2:0] ports;
		logic [11:0] vlan_identifier;
		logic [3:0] filter_identifier;
	} mvl_row_t;
	localparam logic [47:0] MA = 48'hA0;
	localparam logic [47:0] M1 = 48'h11;
	localparam logic [47:0] M2 = 48'h22;
	localparam logic [47:0] M3 = 48'h33;
	logic clock, rst_b, ctrl_wr, dw_wr, vlan_mode_en;
	logic pkt_valid, pkt_tagged, static_hit;
	logic pkt_ready_q, fwd_valid_q, fwd_drop_q;
	logic [15:0] indirect_access_control_word, dw_wdata;
	logic [2:0] dw_sel, static_ports, fwd_ports_q;
	logic [11:0] default_vid_p1, default_vid_p2, default_vid_p3;
	logic [11:0] pkt_tag_vid, fwd_vid_q;
	logic [1:0] pkt_ingress;
	logic [47:0] pkt_da, pkt_sa;
	logic [7:0] indirect_data_word_one_q;
	logic [15:0] indirect_data_word_two_q, indirect_data_word_three_q;
	logic [15:0] indirect_data_word_four_q, indirect_data_word_five_q;
	logic [3:0] fwd_filter_identifier_q;
	int failures, comparisons, n;
	mvl_row_t rows [9];

	mvl_lookup_top #(.AGE_TICK_CYCLES(4)) i_mvl_lookup_top (.clock, .rst_b,
		.ctrl_wr, .indirect_access_control_word, .dw_wr, .dw_sel, .dw_wdata,
		.indirect_data_word_one_q, .indirect_data_word_two_q,
		.indirect_data_word_three_q, .indirect_data_word_four_q,
		.indirect_data_word_five_q, .vlan_mode_en, .default_vid_p1,
		.default_vid_p2, .default_vid_p3, .pkt_valid, .pkt_ingress,
		.pkt_tagged, .pkt_tag_vid, .pkt_da, .pkt_sa, .static_hit,
		.static_ports, .pkt_ready_q, .fwd_valid_q, .fwd_drop_q,
		.fwd_ports_q, .fwd_vid_q, .fwd_filter_identifier_q);

	// core clock, 100 ns period
	initial
	begin
		clock = 1'h0;
		forever #50 clock = ~clock;
	end

	// compare one value and count it
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// print counts and the verdict, then end the run
	task automatic stop_test();
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// one host write of control word (ctl) or data word, then wait ready
	task automatic host(input logic ctl, input logic [2:0] sel,
		input logic [15:0] v);
		@(negedge clock);
		ctrl_wr = ctl;
		dw_wr = !ctl;
		dw_sel = sel;
		indirect_access_control_word = v;
		dw_wdata = v;
		@(negedge clock);
		ctrl_wr = 1'h0;
		dw_wr = 1'h0;
		n = 0;
		while (indirect_data_word_one_q[7] !== 1'h0 && n < 20)
		begin
			@(negedge clock);
			n++;
		end
	endtask

	// offer one packet descriptor and compare its forwarding result
	task automatic send(input mvl_row_t r);
		n = 0;
		while (pkt_ready_q !== 1'h1 && n < 20)
		begin
			@(negedge clock);
			n++;
		end
		pkt_valid = 1'h1;
		{pkt_ingress, pkt_tagged, pkt_tag_vid, pkt_da, pkt_sa} =
			{r.ing, r.tg, r.tv, r.da, r.sa};
		{static_hit, static_ports} = {r.sh, r.sp};
		@(negedge clock);
		pkt_valid = 1'h0;
		n = 0;
		while (fwd_valid_q !== 1'h1 && n < 10)
		begin
			@(negedge clock);
			n++;
		end
		check(fwd_valid_q, 16'h1);
		check(fwd_drop_q, r.drop);
		if (!r.drop)
		begin
			check(fwd_ports_q, r.ports);
			check(fwd_vid_q, r.vlan_identifier);
			check(fwd_filter_identifier_q, r.filter_identifier);
		end
	endtask

	// main sequence
	initial
	begin
		rows[0] = '{2'h0, 1'h0, 12'h0, MA, M1, 1'h0, 3'h0, 1'h0, 3'h6, 12'h1, 4'h0};
		rows[1] = '{2'h1, 1'h1, 12'h0, MA, M2, 1'h0, 3'h0, 1'h0, 3'h1, 12'hA, 4'h3};
		rows[2] = '{2'h2, 1'h0, 12'h0, MA, M3, 1'h0, 3'h0, 1'h1, 3'h0, 12'h5, 4'h0};
		rows[3] = '{2'h0, 1'h1, 12'hA, M2, M1, 1'h0, 3'h0, 1'h0, 3'h2, 12'hA, 4'h3};
		rows[4] = '{2'h1, 1'h1, 12'h1, M1, M2, 1'h0, 3'h0, 1'h0, 3'h1, 12'h1, 4'h0};
		rows[5] = '{2'h2, 1'h1, 12'hA, M3, M1, 1'h0, 3'h0, 1'h0, 3'h3, 12'hA, 4'h3};
		rows[6] = '{2'h1, 1'h1, 12'h1, MA, M2, 1'h1, 3'h7, 1'h0, 3'h5, 12'h1, 4'h0};
		rows[7] = '{2'h0, 1'h1, 12'h7FF, MA, M1, 1'h0, 3'h0, 1'h1, 3'h0, 12'h7FF, 4'h0};
		rows[8] = '{2'h2, 1'h0, 12'h0, MA, M3, 1'h0, 3'h0, 1'h0, 3'h3, 12'h5, 4'h0};
		{ctrl_wr, dw_wr, pkt_valid, pkt_tagged, static_hit} = 5'h0;
		{indirect_access_control_word, dw_wdata, dw_sel} = 35'h0;
		{pkt_ingress, pkt_tag_vid, pkt_da, pkt_sa, static_ports} = 113'h0;
		{default_vid_p1, default_vid_p2, default_vid_p3} = 36'h001_00A_005;
		vlan_mode_en = 1'h1;
		failures = 0;
		comparisons = 0;
		rst_b = 1'h0;
		repeat (12) @(negedge clock);
		rst_b = 1'h1;
		@(negedge clock);
		check(indirect_data_word_one_q, 16'h04);
		host(1'h1, 3'h0, 16'h1800);
		check(indirect_data_word_one_q, 16'h04);
		host(1'h1, 3'h0, 16'h1402);
		check(indirect_data_word_five_q, 16'h000F);
		check(indirect_data_word_four_q, 16'h0001);
		host(1'h0, mvl_pkg::DW_FIVE, 16'h000B);
		host(1'h0, mvl_pkg::DW_FOUR, 16'h300A);
		host(1'h1, 3'h0, 16'h0406);
		host(1'h1, 3'h0, 16'h1406);
		check(indirect_data_word_five_q, 16'h000B);
		check(indirect_data_word_four_q, 16'h300A);
		for (int i = 0; i < 8; i++)
			send(rows[i]);
		// a refused learned-table write, then read the entry back
		host(1'h0, mvl_pkg::DW_FOUR, 16'hFFFF);
		host(1'h1, 3'h0, 16'h0811);
		host(1'h1, 3'h0, 16'h1811);
		check(indirect_data_word_one_q, 16'h00);
		check(indirect_data_word_three_q & 16'hFF3F, 16'h0300);
		check(indirect_data_word_two_q, 16'h0000);
		check(indirect_data_word_five_q, 16'h0000);
		check(indirect_data_word_four_q, 16'h0011);
		vlan_mode_en = 1'h0;
		send(rows[8]);
		// mid-run reset empties the learned table view again
		rst_b = 1'h0;
		repeat (2) @(negedge clock);
		rst_b = 1'h1;
		@(negedge clock);
		check(indirect_data_word_one_q, 16'h04);
		host(1'h1, 3'h0, 16'h1811);
		check(indirect_data_word_one_q, 16'h04);
		stop_test();
	end

	// watchdog, well beyond the fewer than one hundred cycles of work
	initial
	begin
		#(100 * 5000);
		failures++;
		stop_test();
	end
endmodule

// ==== pkg/mvl_pkg.sv ====
// constants, types and helper functions for the mac and vlan lookup tables
package mvl_pkg;
	// learned-address table geometry
	localparam int unsigned LRN_DEPTH = 1024;
	localparam int unsigned LRN_AW = 10;
	localparam int unsigned LRN_EW = 56;
	localparam int unsigned LRN_CNT_W = 11;
	// learned entry fields (bits 55-0 of the returned entry)
	localparam int unsigned LE_TS_LSB = 54;
	localparam int unsigned LE_PORT_LSB = 52;
	localparam int unsigned LE_FID_LSB = 48;
	localparam int unsigned LE_MAC_LSB = 0;
	// returned entry upper word, bits 71-64
	localparam int unsigned RD_BUSY_BIT = 7;
	localparam int unsigned RD_EMPTY_BIT = 2;
	// vlan table geometry and fields
	localparam int unsigned VT_DEPTH = 16;
	localparam int unsigned VT_IW = 4;
	localparam int unsigned VT_EW = 20;
	localparam int unsigned VT_VALID_BIT = 19;
	localparam int unsigned VT_MEMB_LSB = 16;
	localparam int unsigned VT_FID_LSB = 12;
	localparam int unsigned VT_VID_LSB = 0;
	localparam logic [19:0] VT_RESET = 20'hF0001;
	// indirect access control word layout
	localparam int unsigned CMD_READ_BIT = 12;
	localparam int unsigned CMD_SEL_LSB = 10;
	localparam logic [1:0] CMD_SEL_VLAN = 2'h1;
	localparam logic [1:0] CMD_SEL_LEARN = 2'h2;
	// data word selects
	localparam logic [2:0] DW_ONE = 3'h1;
	localparam logic [2:0] DW_TWO = 3'h2;
	localparam logic [2:0] DW_THREE = 3'h3;
	localparam logic [2:0] DW_FOUR = 3'h4;
	localparam logic [2:0] DW_FIVE = 3'h5;
	// aging tick period in core clock cycles
	localparam int unsigned AGE_TICK_CYCLES = 10000000;
	// lookup engine states
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_VLAN = 3'b001,
		ST_DA = 3'b010,
		ST_SA = 3'b011,
		ST_HOST = 3'b100
	} mvl_state_t;
	// table index from filter identifier and station address
	function automatic logic [9:0] mvl_hash(input logic [3:0] filter_identifier,
		input logic [47:0] mac);
		mvl_hash = mac[9:0] ^ mac[19:10] ^ mac[29:20] ^ mac[39:30] ^
			{2'h0, mac[47:40]} ^ {6'h00, filter_identifier};
	endfunction
	// port code 00/01/10 to a one-hot port mask
	function automatic logic [2:0] mvl_port_mask(input logic [1:0] code);
		unique case (code)
			2'h0: mvl_port_mask = 3'h1;
			2'h1: mvl_port_mask = 3'h2;
			2'h2: mvl_port_mask = 3'h4;
			default: mvl_port_mask = 3'h0;
		endcase
	endfunction
endpackage

// ==== rtl/mvl_learn_table.sv ====
// learned-address storage with valid flags and occupancy count
`timescale 1ns/10ps
module mvl_learn_table
#(
	parameter int unsigned DEPTH = 1024,
	parameter int unsigned AW = 10,
	parameter int unsigned EW = 56,
	parameter int unsigned CW = 11
)
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// registered read port
	input wire logic [AW-1:0] rd_addr,
	output logic [EW-1:0] rd_data,
	output logic rd_valid,
	// write port, used only by learning
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [EW-1:0] wr_data,
	// number of valid entries
	output logic [CW-1:0] count
);
	if (DEPTH != (1 << AW) || CW <= AW)
		$error("mvl_learn_table: depth, address and count widths disagree");

	logic [EW-1:0] mem [DEPTH];
	logic [DEPTH-1:0] valid_q, valid_d;
	logic [CW-1:0] count_q, count_d;
	logic [EW-1:0] rd_data_q;
	logic rd_valid_q, rd_valid_d;

	// a write to an empty slot adds one entry; replacement keeps count
	always_comb
	begin
		valid_d = valid_q;
		count_d = count_q;
		rd_valid_d = valid_q[rd_addr];
		if (wr_en)
		begin
			valid_d[wr_addr] = 1'b1;
			if (!valid_q[wr_addr])
				count_d = count_q + CW'(1);
		end
	end

	// flags and count
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			valid_q <= '0;
			count_q <= '0;
			rd_valid_q <= 1'b0;
		end
		else
		begin
			valid_q <= valid_d;
			count_q <= count_d;
			rd_valid_q <= rd_valid_d;
		end
	end

	// storage array, no reset
	always_ff @(posedge clock)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		rd_data_q <= mem[rd_addr];
	end

	assign rd_data = rd_data_q;
	assign rd_valid = rd_valid_q;
	assign count = count_q;
endmodule

// ==== rtl/mvl_lookup_top.sv ====
// forwarding lookup with learned-address and vlan tables
//
// Summary of operation
// RL1 - learned table has 1024 entries; host writes never change them
// RL2 - returned bit 71 reads 1 until the entry is ready, then 0
// RL3 - bit 66 is 1 while the table is empty; resets to 1
// RL4 - bits 65-56 give valid count minus one; 0x3ff is full
// RL5 - bits 55-54 hold the aging timestamp counter of the entry
// RL6 - bits 53-52 give learned port: 00 port1, 01 port2, 10 port3
// RL7 - bits 51-48 filter identifier, bits 47-0 station address
// RL8 - host reads entry zero with 0x1800, then words 1,3,2,5,4
// RL9 - vlan mode bit makes every packet consult the vlan table
// RL10 - vlan entry bit 19 marks it valid; resets to 1
// RL11 - bits 18-16 membership, reset 111; destination miss floods members
// RL12 - bits 15-12 filter identifier; lookups keyed on it plus address
// RL13 - bits 11-0 hold the vlan identifier, reset 0x001
// RL14 - untagged or null-tagged packets take the port default vid
// RL15 - unknown or invalid vid drops the packet without learning
// RL16 - destination lookup picks ports; miss floods members except ingress
// RL17 - a source lookup miss learns identifier plus address
// RL18 - host reads vlan entry 2 with 0x1402, then words 5 and 4
// RL19 - host loads words 5 and 4, then control word updates entry
// RL20 - static destination hit wins; source lookups use learned table only
// RL21 - control word: bit 12 read, bits 11-10 table, low bits offset
`timescale 1ns/10ps
module mvl_lookup_top
#(
	parameter int unsigned AGE_TICK_CYCLES = mvl_pkg::AGE_TICK_CYCLES
)
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// host indirect access
	input wire logic ctrl_wr,
	input wire logic [15:0] indirect_access_control_word,
	input wire logic dw_wr,
	input wire logic [2:0] dw_sel,
	input wire logic [15:0] dw_wdata,
	output logic [7:0] indirect_data_word_one_q,
	output logic [15:0] indirect_data_word_two_q,
	output logic [15:0] indirect_data_word_three_q,
	output logic [15:0] indirect_data_word_four_q,
	output logic [15:0] indirect_data_word_five_q,
	// configuration
	input wire logic vlan_mode_en,
	input wire logic [11:0] default_vid_p1,
	input wire logic [11:0] default_vid_p2,
	input wire logic [11:0] default_vid_p3,
	// ingress packet descriptor
	input wire logic pkt_valid,
	input wire logic [1:0] pkt_ingress,
	input wire logic pkt_tagged,
	input wire logic [11:0] pkt_tag_vid,
	input wire logic [47:0] pkt_da,
	input wire logic [47:0] pkt_sa,
	input wire logic static_hit,
	input wire logic [2:0] static_ports,
	output logic pkt_ready_q,
	// forwarding result
	output logic fwd_valid_q,
	output logic fwd_drop_q,
	output logic [2:0] fwd_ports_q,
	output logic [11:0] fwd_vid_q,
	output logic [3:0] fwd_filter_identifier_q
);
	if (AGE_TICK_CYCLES < 2)
		$error("mvl_lookup_top: aging tick period too short");

	mvl_pkg::mvl_state_t state_q, state_d;
	logic [31:0] age_cnt_q, age_cnt_d;
	logic [1:0] ts_q, ts_d;
	logic host_pend_q, host_pend_d;
	logic [9:0] host_off_q, host_off_d;
	logic [1:0] ing_q, ing_d;
	logic tagged_q, tagged_d;
	logic [11:0] tag_vid_q, tag_vid_d;
	logic [47:0] da_q, da_d;
	logic [47:0] sa_q, sa_d;
	logic st_hit_q, st_hit_d;
	logic [2:0] st_ports_q, st_ports_d;
	logic [3:0] fid_q, fid_d;
	logic [11:0] vid_q, vid_d;
	logic [2:0] memb_q, memb_d;
	logic da_hit_q, da_hit_d;
	logic [2:0] da_ports_q, da_ports_d;
	logic [7:0] w1_d;
	logic [15:0] w2_d, w3_d, w4_d, w5_d;
	logic ready_d, fvalid_d, fdrop_d;
	logic [2:0] fports_d;
	logic [11:0] fvid_d;
	logic [3:0] ffid_d;
	logic [11:0] vid_asg;
	logic [2:0] egress;
	logic lrn_hit;
	logic [9:0] rd_addr;
	logic [55:0] rd_data;
	logic rd_valid;
	logic wr_en;
	logic [9:0] wr_addr;
	logic [55:0] wr_data;
	logic [10:0] count;
	logic [9:0] count_field;
	logic vt_wr;
	logic [19:0] vt_rd, vt_ent;
	logic vt_hit;
	logic [1:0] cmd_sel;
	logic cmd_read;
	logic lrn_rd;

	// RL21 command word fields
	assign cmd_read = indirect_access_control_word[mvl_pkg::CMD_READ_BIT];
	assign cmd_sel = indirect_access_control_word[mvl_pkg::CMD_SEL_LSB +: 2];
	assign lrn_rd = ctrl_wr && cmd_read && cmd_sel == mvl_pkg::CMD_SEL_LEARN;
	// RL19 vlan table update
	assign vt_wr = ctrl_wr && !cmd_read && cmd_sel == mvl_pkg::CMD_SEL_VLAN;

	mvl_vlan_table u_vlan
	(
		.clock(clock),
		.rst_b(rst_b),
		.wr_en(vt_wr),
		.idx(indirect_access_control_word[3:0]),
		.wr_data({indirect_data_word_five_q[3:0],
			indirect_data_word_four_q}),
		.rd_data(vt_rd),
		.search_vid(vid_asg),
		.search_hit(vt_hit),
		.search_entry(vt_ent)
	);

	// RL1 learned table storage
	mvl_learn_table
	#(
		.DEPTH(mvl_pkg::LRN_DEPTH),
		.AW(mvl_pkg::LRN_AW),
		.EW(mvl_pkg::LRN_EW),
		.CW(mvl_pkg::LRN_CNT_W)
	)
	u_learn
	(
		.clock(clock),
		.rst_b(rst_b),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_valid(rd_valid),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.count(count)
	);

	// RL14 vid assignment from tag or ingress port default
	always_comb
	begin
		if (tagged_q && tag_vid_q != 12'h000)
			vid_asg = tag_vid_q;
		else
			unique case (ing_q)
				2'h0: vid_asg = default_vid_p1;
				2'h1: vid_asg = default_vid_p2;
				default: vid_asg = default_vid_p3;
			endcase
	end

	// RL4 count minus one, zero when empty
	assign count_field = (count == 11'h000) ? 10'h000 :
		10'(count - 11'h001);
	// RL12 learned match needs filter identifier and address
	assign lrn_hit = rd_valid && rd_data[mvl_pkg::LE_FID_LSB +: 4] == fid_q;

	// RL20 static hit first, then learned, else RL11 members
	always_comb
	begin
		if (st_hit_q)
			egress = st_ports_q;
		else if (da_hit_q)
			egress = da_ports_q;
		else
			egress = memb_q;
		// RL16 never back out of the ingress port
		egress = egress & ~mvl_pkg::mvl_port_mask(ing_q);
	end

	// lookup engine, host access and aging next state
	always_comb
	begin
		state_d = state_q;
		age_cnt_d = age_cnt_q + 32'h1;
		ts_d = ts_q;
		host_pend_d = host_pend_q;
		host_off_d = host_off_q;
		ing_d = ing_q;
		tagged_d = tagged_q;
		tag_vid_d = tag_vid_q;
		da_d = da_q;
		sa_d = sa_q;
		st_hit_d = st_hit_q;
		st_ports_d = st_ports_q;
		fid_d = fid_q;
		vid_d = vid_q;
		memb_d = memb_q;
		da_hit_d = da_hit_q;
		da_ports_d = da_ports_q;
		w1_d = indirect_data_word_one_q;
		w2_d = indirect_data_word_two_q;
		w3_d = indirect_data_word_three_q;
		w4_d = indirect_data_word_four_q;
		w5_d = indirect_data_word_five_q;
		fvalid_d = 1'b0;
		fdrop_d = 1'b0;
		fports_d = fwd_ports_q;
		fvid_d = fwd_vid_q;
		ffid_d = fwd_filter_identifier_q;
		rd_addr = host_off_q;
		wr_en = 1'b0;
		wr_addr = mvl_pkg::mvl_hash(fid_q, sa_q);
		wr_data = {ts_q, ing_q, fid_q, sa_q};
		// RL5 timestamp counter advances on each aging tick
		if (age_cnt_q == 32'(AGE_TICK_CYCLES - 1))
		begin
			age_cnt_d = 32'h0;
			ts_d = ts_q + 2'h1;
		end
		// host loads data words
		if (dw_wr)
			unique case (dw_sel)
				mvl_pkg::DW_ONE: w1_d = dw_wdata[7:0];
				mvl_pkg::DW_TWO: w2_d = dw_wdata;
				mvl_pkg::DW_THREE: w3_d = dw_wdata;
				mvl_pkg::DW_FOUR: w4_d = dw_wdata;
				mvl_pkg::DW_FIVE: w5_d = dw_wdata;
				default: ;
			endcase
		// RL18 vlan read lands in words five and four
		if (ctrl_wr && cmd_read && cmd_sel == mvl_pkg::CMD_SEL_VLAN)
		begin
			w5_d = {12'h000, vt_rd[19:16]};
			w4_d = vt_rd[15:0];
		end
		// RL2 learned read: not ready until the entry is fetched
		if (lrn_rd)
		begin
			host_pend_d = 1'b1;
			host_off_d = indirect_access_control_word[9:0];
			w1_d[mvl_pkg::RD_BUSY_BIT] = 1'b1;
		end
		unique case (state_q)
			mvl_pkg::ST_IDLE:
			begin
				if (host_pend_q)
				begin
					// a read arriving now stays pending: set wins
					host_pend_d = lrn_rd;
					state_d = mvl_pkg::ST_HOST;
				end
				else if (pkt_valid && pkt_ready_q)
				begin
					ing_d = pkt_ingress;
					tagged_d = pkt_tagged;
					tag_vid_d = pkt_tag_vid;
					da_d = pkt_da;
					sa_d = pkt_sa;
					st_hit_d = static_hit;
					st_ports_d = static_ports;
					state_d = mvl_pkg::ST_VLAN;
				end
			end
			mvl_pkg::ST_VLAN:
			begin
				// RL9 vlan table consulted only in vlan mode
				if (vlan_mode_en)
				begin
					vid_d = vid_asg;
					fid_d = vt_ent[mvl_pkg::VT_FID_LSB +: 4];
					memb_d = vt_ent[mvl_pkg::VT_MEMB_LSB +: 3];
				end
				else
				begin
					vid_d = vid_asg;
					fid_d = 4'h0;
					memb_d = 3'h7;
				end
				rd_addr = mvl_pkg::mvl_hash(fid_d, da_q);
				// RL15 invalid vid drops, skips learning
				if (vlan_mode_en && !vt_hit)
				begin
					fvalid_d = 1'b1;
					fdrop_d = 1'b1;
					fports_d = 3'h0;
					fvid_d = vid_asg;
					ffid_d = 4'h0;
					state_d = mvl_pkg::ST_IDLE;
				end
				else
					state_d = mvl_pkg::ST_DA;
			end
			mvl_pkg::ST_DA:
			begin
				// RL16 destination lookup result
				da_hit_d = lrn_hit &&
					rd_data[mvl_pkg::LE_MAC_LSB +: 48] == da_q;
				da_ports_d = mvl_pkg::mvl_port_mask(
					rd_data[mvl_pkg::LE_PORT_LSB +: 2]);
				// RL20 source lookup searches the learned table only
				rd_addr = mvl_pkg::mvl_hash(fid_q, sa_q);
				state_d = mvl_pkg::ST_SA;
			end
			mvl_pkg::ST_SA:
			begin
				// RL17 learn on a miss; a hit refreshes time and port
				wr_en = 1'b1;
				fvalid_d = 1'b1;
				fports_d = egress;
				fvid_d = vid_q;
				ffid_d = fid_q;
				state_d = mvl_pkg::ST_IDLE;
			end
			mvl_pkg::ST_HOST:
			begin
				// RL3 RL4 RL6 RL7 entry and table status into words
				w1_d = {1'b0, 4'h0, count == 11'h000, count_field[9:8]};
				w3_d = {count_field[7:0], rd_data[55:48]};
				w2_d = rd_data[47:32];
				w5_d = rd_data[31:16];
				w4_d = rd_data[15:0];
				if (host_pend_d)
					w1_d[mvl_pkg::RD_BUSY_BIT] = 1'b1;
				state_d = mvl_pkg::ST_IDLE;
			end
			default: state_d = mvl_pkg::ST_IDLE;
		endcase
		ready_d = state_d == mvl_pkg::ST_IDLE && !host_pend_d;
	end

	// register all state; words reset to an idle, empty-table view
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			state_q <= mvl_pkg::ST_IDLE;
			age_cnt_q <= 32'h0;
			ts_q <= 2'h0;
			host_pend_q <= 1'b0;
			host_off_q <= 10'h000;
			ing_q <= 2'h0;
			tagged_q <= 1'b0;
			tag_vid_q <= 12'h000;
			da_q <= 48'h0;
			sa_q <= 48'h0;
			st_hit_q <= 1'b0;
			st_ports_q <= 3'h0;
			fid_q <= 4'h0;
			vid_q <= 12'h000;
			memb_q <= 3'h7;
			da_hit_q <= 1'b0;
			da_ports_q <= 3'h0;
			// RL3 empty flag resets to 1
			indirect_data_word_one_q <= 8'h04;
			indirect_data_word_two_q <= 16'h0000;
			indirect_data_word_three_q <= 16'h0000;
			indirect_data_word_four_q <= 16'h0000;
			indirect_data_word_five_q <= 16'h0000;
			pkt_ready_q <= 1'b0;
			fwd_valid_q <= 1'b0;
			fwd_drop_q <= 1'b0;
			fwd_ports_q <= 3'h0;
			fwd_vid_q <= 12'h000;
			fwd_filter_identifier_q <= 4'h0;
		end
		else
		begin
			state_q <= state_d;
			age_cnt_q <= age_cnt_d;
			ts_q <= ts_d;
			host_pend_q <= host_pend_d;
			host_off_q <= host_off_d;
			ing_q <= ing_d;
			tagged_q <= tagged_d;
			tag_vid_q <= tag_vid_d;
			da_q <= da_d;
			sa_q <= sa_d;
			st_hit_q <= st_hit_d;
			st_ports_q <= st_ports_d;
			fid_q <= fid_d;
			vid_q <= vid_d;
			memb_q <= memb_d;
			da_hit_q <= da_hit_d;
			da_ports_q <= da_ports_d;
			indirect_data_word_one_q <= w1_d;
			indirect_data_word_two_q <= w2_d;
			indirect_data_word_three_q <= w3_d;
			indirect_data_word_four_q <= w4_d;
			indirect_data_word_five_q <= w5_d;
			pkt_ready_q <= ready_d;
			fwd_valid_q <= fvalid_d;
			fwd_drop_q <= fdrop_d;
			fwd_ports_q <= fports_d;
			fwd_vid_q <= fvid_d;
			fwd_filter_identifier_q <= ffid_d;
		end
	end
endmodule

// ==== rtl/mvl_vlan_table.sv ====
// sixteen-entry vlan table with host port and vid search
`timescale 1ns/10ps
module mvl_vlan_table
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// host access
	input wire logic wr_en,
	input wire logic [3:0] idx,
	input wire logic [19:0] wr_data,
	output logic [19:0] rd_data,
	// lookup search
	input wire logic [11:0] search_vid,
	output logic search_hit,
	output logic [19:0] search_entry
);
	logic [19:0] ent_q [mvl_pkg::VT_DEPTH];
	logic [19:0] ent_d [mvl_pkg::VT_DEPTH];

	// next contents: host write of one entry
	always_comb
	begin
		for (int i = 0; i < mvl_pkg::VT_DEPTH; i++)
			ent_d[i] = ent_q[i];
		if (wr_en)
			ent_d[idx] = wr_data;
	end

	// RL10 RL11 RL13 reset to valid entries
	always_ff @(posedge clock)
	begin
		for (int i = 0; i < mvl_pkg::VT_DEPTH; i++)
			ent_q[i] <= rst_b ? ent_d[i] : mvl_pkg::VT_RESET;
	end

	// RL10 only valid entries match
	always_comb
	begin
		rd_data = ent_q[idx];
		search_hit = 1'b0;
		search_entry = 20'h00000;
		for (int i = mvl_pkg::VT_DEPTH - 1; i >= 0; i--)
			if (ent_q[i][mvl_pkg::VT_VALID_BIT] &&
				ent_q[i][11:0] == search_vid)
			begin
				search_hit = 1'b1;
				search_entry = ent_q[i];
			end
	end
endmodule
